// ===== inc/gpio_map.vh
// register offsets, field positions and reset values for the digital port block
// assumes a 32-bit axi4-lite slave; offsets are word indices, byte address is four times
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH
`define OFF_ADDR 4'h0
`define OFF_CTRL 4'h1
`define OFF_PORT_OUT 4'h2
`define OFF_PORT_STAT 4'h3
`define OFF_IRQ_STAT 4'h4
`define OFF_IRQ_EN 4'h5
`define OFF_IRQ_CLR 4'h6
`define CTRL_LISTEN 0
`define CTRL_TALK 1
`define CTRL_SRQ_EN 2
`define STAT_SRQ 8
`define IRQ_CHANGE 0
`define IRQ_REJECT 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ADDR_RESERVED 5'h1f
`define PORT_OUT_RESET 4'h0
`define BOOT_SETTLE 3'h4
`endif

// ===== core/input_sync.v
// three-stage synchroniser with change detect for the port inputs
// assumes asynchronous pins and one clock
module input_sync #(
    parameter WIDTH = 4
)(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // pins and results
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level,
    output reg [WIDTH-1:0] changed
);
    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    reg primed_reg;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_reg <= {WIDTH{1'b1}};
            s2_reg <= {WIDTH{1'b1}};
            s3_reg <= {WIDTH{1'b1}};
            level <= {WIDTH{1'b1}};
            changed <= {WIDTH{1'b0}};
            primed_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            primed_reg <= 1'b1;
            // a bit moves only where stages two and three agree
            level <= (level & (s2_reg ^ s3_reg)) | (s2_reg & s3_reg);
            // first cycle after reset flags nothing; pins low at reset are flagged once stages two and three hold them
            changed <= primed_reg ? ((s2_reg & s3_reg & ~level) | (~s2_reg & ~s3_reg & level))
                : {WIDTH{1'b0}};
        end
    end
endmodule

// ===== core/bus_addr_dio.v
// primary address capture and four-bit digital port, axi4-lite register slave
// assumes one 20 mhz clock, synchronous active-low reset held at power-up,
// address switches static near reset, bus handshake handled elsewhere
//
// Notes on behaviour
// - switches form binary address, first is lsb
// - separate four-bit input and output groups
// - port write sets outputs, held until changed
// - status read returns inputs and outputs
// - enabled input change raises service request
// - bit 0 least, bit 3 most significant
// - switches sampled once after reset release
// - listen needed for commands, talk for reads
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`include "gpio_map.vh"
module bus_addr_dio #(
    parameter PORT_W = 4,
    parameter ADDR_W = 5
)(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address and data
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // address switches
    input wire addr_switch_lsb,
    input wire [2:0] addr_switch_mid,
    input wire addr_switch_msb,
    // digital port
    input wire [PORT_W-1:0] port_in,
    output reg [PORT_W-1:0] port_out,
    // service request and interrupt
    output reg srq,
    output reg irq
);
    // byte address to word index, unmapped above the last register
    function [3:0] word_index;
        input [5:0] a;
        begin
            word_index = {1'b0, a[4:2]} | {a[5], 3'b000};
        end
    endfunction

    wire [PORT_W-1:0] in_level;
    wire [PORT_W-1:0] in_changed;
    input_sync #(.WIDTH(PORT_W)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(port_in),
        .level(in_level),
        .changed(in_changed)
    );

    // switches pass the same three stages before capture
    reg [ADDR_W-1:0] sw1_reg;
    reg [ADDR_W-1:0] sw2_reg;
    reg [ADDR_W-1:0] sw3_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [2:0] boot_cnt_reg;
    reg captured_reg;
    reg [2:0] ctrl_reg;
    reg [PORT_W-1:0] pending_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_en_reg;
    reg aw_held_reg;
    reg w_held_reg;
    reg [3:0] aw_idx_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;

    wire listen = ctrl_reg[`CTRL_LISTEN];
    wire talk = ctrl_reg[`CTRL_TALK];
    wire srq_en = ctrl_reg[`CTRL_SRQ_EN];
    wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire [3:0] ar_idx = word_index(s_axi_araddr);
    wire port_wr = do_write && aw_idx_reg == `OFF_PORT_OUT && wstrb_reg[0];
    wire stat_rd = do_read && ar_idx == `OFF_PORT_STAT;
    // port commands ignored without the matching addressing
    wire wr_reject = port_wr && !listen;
    wire rd_reject = stat_rd && !talk;
    wire [1:0] irq_set = {wr_reject | rd_reject, |in_changed};

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw1_reg <= {ADDR_W{1'b0}};
            sw2_reg <= {ADDR_W{1'b0}};
            sw3_reg <= {ADDR_W{1'b0}};
            addr_reg <= {ADDR_W{1'b0}};
            boot_cnt_reg <= 3'h0;
            captured_reg <= 1'b0;
        end
        else
        begin
            sw1_reg <= {addr_switch_msb, addr_switch_mid, addr_switch_lsb};
            sw2_reg <= sw1_reg;
            sw3_reg <= sw2_reg;
            if (!captured_reg)
            begin
                boot_cnt_reg <= boot_cnt_reg + 3'h1;
                // wait until stages two and three hold real switch data
                if (boot_cnt_reg == `BOOT_SETTLE && sw2_reg == sw3_reg)
                begin
                    addr_reg <= sw3_reg;
                    captured_reg <= 1'b1;
                end
            end
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_idx_reg <= 4'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            ctrl_reg <= 3'h0;
            port_out <= `PORT_OUT_RESET;
            pending_reg <= {PORT_W{1'b0}};
            irq_stat_reg <= 2'h0;
            irq_en_reg <= 2'h0;
            srq <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_idx_reg <= word_index(s_axi_awaddr);
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_idx_reg > `OFF_IRQ_CLR) ? `RESP_SLVERR : `RESP_OKAY;
                if (aw_idx_reg == `OFF_CTRL && wstrb_reg[0])
                    ctrl_reg <= wdata_reg[2:0];
                if (aw_idx_reg == `OFF_IRQ_EN && wstrb_reg[0])
                    irq_en_reg <= wdata_reg[1:0];
                if (port_wr && listen)
                    port_out <= wdata_reg[PORT_W-1:0];
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (do_read)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                s_axi_rdata <= 32'h0;
                case (ar_idx)
                    `OFF_ADDR: s_axi_rdata <= {27'h0, addr_reg};
                    `OFF_CTRL: s_axi_rdata <= {29'h0, ctrl_reg};
                    `OFF_PORT_OUT: s_axi_rdata <= {28'h0, port_out};
                    // inputs in bits 3..0, outputs in 7..4, srq in 8
                    `OFF_PORT_STAT: if (talk) s_axi_rdata <= {23'h0, srq, port_out, in_level};
                    `OFF_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_reg};
                    `OFF_IRQ_EN: s_axi_rdata <= {30'h0, irq_en_reg};
                    `OFF_IRQ_CLR: s_axi_rdata <= 32'h0;
                    default: s_axi_rresp <= `RESP_SLVERR;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            // a talker status read services the request; new changes win
            if (stat_rd && talk)
                pending_reg <= in_changed;
            else
                pending_reg <= pending_reg | in_changed;
            srq <= srq_en && (|pending_reg);
            // clear register; set wins over clear
            if (do_write && aw_idx_reg == `OFF_IRQ_CLR && wstrb_reg[0])
                irq_stat_reg <= (irq_stat_reg & ~wdata_reg[1:0]) | irq_set;
            else
                irq_stat_reg <= irq_stat_reg | irq_set;
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end
endmodule

// ===== sim/bus_addr_dio_sva.sv
// checker for the address capture and digital port block
// assumes bind to the design top and a single clock
module bus_addr_dio_sva (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // port and requests
    input wire logic [3:0] port_out,
    input wire logic srq,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_clears: assert property (disable iff (1'b0) !aresetn |=> port_out == 4'h0 && !srq && !irq)
        else $error("outputs not cleared by reset");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_readies_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("ready high while response pending");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
        else $error("unused read bits set");
    a_out_on_write: assert property (!$stable(port_out) |-> $rose(s_axi_bvalid))
        else $error("outputs moved without a write");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($rose(srq));
    cover property ($fell(irq));
endmodule
bind bus_addr_dio bus_addr_dio_sva i_bus_addr_dio_sva (.*);

// ===== sim/bus_ctl_model.sv
// bus controller model: register bus master with write and read tasks
// assumes the bench top holds mismatches and tally_and_finish
module bus_ctl_model (
    // clock
    input wire logic aclk,
    // write channels
    output logic [5:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // read channels
    output logic [5:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = 45'h0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = 8'h0;
    end
    task automatic fail();
        bus_addr_dio_tb_top.mismatches++;
        bus_addr_dio_tb_top.tally_and_finish();
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (64)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        fail();
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        repeat (64)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                s_axi_rready <= 1'b0;
                d = s_axi_rdata;
                r = s_axi_rresp;
                return;
            end
        end
        fail();
    endtask
endmodule

// ===== sim/bus_addr_dio_tb_top.sv
// bench top: address capture, port writes and reads, service request
// assumes bus_ctl_model drives the register bus
module bus_addr_dio_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, addr_switch_lsb, addr_switch_msb, srq, irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, port_in, port_out;
    logic [4:0] sw;
    logic [2:0] addr_switch_mid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int mismatches = 0;
    int checked = 0;
    int i;
    bus_addr_dio i_bus_addr_dio (.*);
    bus_ctl_model i_bus_ctl_model (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        i_bus_ctl_model.rd(a, d, r);
        chk(d, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial
    begin
        aresetn = 1'b0;
        port_in = 4'hf;
        {addr_switch_msb, addr_switch_mid, addr_switch_lsb} = 5'h0;
        tick(1);
        // switches moved after capture must not matter; 31 never set
        for (i = 0; i < 6; i++)
        begin
            sw = (i < 5) ? 5'h1 << i : 5'h1e;
            aresetn <= 1'b0;
            {addr_switch_msb, addr_switch_mid, addr_switch_lsb} <= sw;
            tick(10);
            aresetn <= 1'b1;
            tick(8);
            {addr_switch_msb, addr_switch_mid, addr_switch_lsb} <= ~sw;
            rdc(6'h00, {27'h0, sw});
        end
        i_bus_ctl_model.wr(6'h08, 32'h5);
        chk(port_out, 32'h0);
        chk(s_axi_bresp, 32'h0);
        rdc(6'h10, 32'h2);
        i_bus_ctl_model.wr(6'h18, 32'h3);
        i_bus_ctl_model.wr(6'h04, 32'h7);
        for (i = 0; i < 2; i++)
        begin
            i_bus_ctl_model.wr(6'h08, 32'h5 << i);
            chk(port_out, 32'h5 << i);
        end
        rdc(6'h0c, 32'h0af);
        i_bus_ctl_model.wr(6'h14, 32'h1);
        port_in <= 4'h6;
        tick(8);
        chk(srq, 1'b1);
        chk(irq, 1'b1);
        rdc(6'h10, 32'h1);
        i_bus_ctl_model.wr(6'h18, 32'h1);
        tick(2);
        chk(irq, 1'b0);
        rdc(6'h0c, 32'h1a6);
        tick(3);
        chk(srq, 1'b0);
        i_bus_ctl_model.wr(6'h04, 32'h1);
        port_in <= 4'h9;
        tick(8);
        chk(srq, 1'b0);
        rdc(6'h0c, 32'h0);
        rdc(6'h10, 32'h3);
        rdc(6'h1c, 32'h0);
        chk(r, 32'h2);
        i_bus_ctl_model.wr(6'h1c, 32'h0);
        chk(s_axi_bresp, 32'h2);
        tally_and_finish();
    end
endmodule
